// *** rtl/fdc_read_data_sequencer.sv ***
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fdc_rd_defs.svh"

module fdc_read_data_sequencer (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host dma, terminal count, interrupt
  input wire logic transfer_end_input,
  input wire logic dma_ack,
  output logic dma_req,
  output logic [7:0] dma_data,
  output logic int_req,
  // drive control
  input wire logic seek_done,
  output logic seek_req,
  output logic [7:0] seek_track,
  output logic [1:0] drive_select,
  output logic head_select,
  output logic read_gate,
  // data separator
  input wire logic index_pulse,
  input wire logic id_valid,
  input wire logic [7:0] id_track,
  input wire logic [7:0] id_head,
  input wire logic [7:0] id_sector,
  input wire logic [7:0] id_size,
  input wire logic id_crc_err,
  input wire logic mark_valid,
  input wire logic mark_deleted,
  input wire logic disk_byte_valid,
  input wire logic [7:0] disk_byte,
  input wire logic crc_valid,
  input wire logic crc_err
);

  // bytes handed to the host for one sector
  function automatic logic [13:0] xfer_bytes(input logic [7:0] code,
                                             input logic [7:0] len);
    logic [7:0] capped;
    logic [13:0] full;
    capped = (code > `SIZE_CODE_MAX) ? `SIZE_CODE_MAX : code;
    full = `MIN_SECTOR_BYTES << capped;
    if (code != 8'h00)
      xfer_bytes = full;
    else if (len < 8'h80)
      xfer_bytes = {6'h00, len};
    else
      xfer_bytes = full;
  endfunction : xfer_bytes

  fdc_rd_pkg::seq_state_t state;
  fdc_rd_pkg::seq_state_t next_state;
  logic [7:0] prm [0:7];
  logic [2:0] pcnt;
  logic opc_mt;
  logic opc_sk;
  logic [7:0] trk;
  logic [7:0] hdn;
  logic [7:0] sec;
  logic [7:0] mode;
  logic [7:0] st1;
  logic [7:0] st2;
  logic term_abn;
  logic tc_seen;
  logic rd_sector;
  logic del_seen;
  logic [1:0] revs;
  logic [11:0] settle;
  logic [13:0] bcnt;
  logic hold_valid;
  logic [2:0] ridx;

  // apb decode
  wire acc = psel & penable;
  wire acc_first = acc & ~pready;
  wire acc_done = acc & pready;
  wire sel_data = (paddr == `OFF_DATA);
  wire sel_stat = (paddr == `OFF_STAT);
  wire sel_mode = (paddr == `OFF_MODE);
  wire addr_ok = sel_data | sel_stat | sel_mode;
  wire wr_data = acc_done & pwrite & sel_data;
  wire rd_data = acc_done & ~pwrite & sel_data;
  wire wr_mode = acc_done & pwrite & sel_mode;

  // command parameters
  wire implied_seek_flag = prm[0][7];
  wire [7:0] sz = prm[4];
  wire [7:0] last_sector_number = prm[5];
  wire [7:0] dtl = prm[7];
  wire [13:0] xfer_len = xfer_bytes(sz, dtl);

  // sequencing events
  wire st_idle = (state == fdc_rd_pkg::S_IDLE);
  wire st_cmd = (state == fdc_rd_pkg::S_CMD);
  wire st_seek = (state == fdc_rd_pkg::S_SEEK);
  wire st_settle = (state == fdc_rd_pkg::S_SETTLE);
  wire st_search = (state == fdc_rd_pkg::S_SEARCH);
  wire st_data = (state == fdc_rd_pkg::S_DATA);
  wire st_result = (state == fdc_rd_pkg::S_RESULT);
  wire opc_ok = wr_data & st_idle & (pwdata[4:0] == `OPC_READ);
  wire cmd_last = wr_data & st_cmd & (pcnt == `PARAM_LAST);
  wire seek_en = mode[`MODE_IPS_BIT] & implied_seek_flag;
  wire abort = wr_data & (st_seek | st_settle | st_search);
  wire id_match;
  wire id_bad_trk;
  wire id_wrong_trk;
  wire id_hit = st_search & id_valid & id_match;
  wire addr_crc = id_hit & id_crc_err;
  wire nodata = st_search & index_pulse & ~id_hit &
                (revs == `NODATA_INDEX);
  wire skip_del = st_data & ~rd_sector & mark_valid & mark_deleted & opc_sk;
  wire sector_done = st_data & rd_sector & crc_valid & ~crc_err;
  wire data_bad = st_data & rd_sector & crc_valid & crc_err;
  wire next_done = sector_done | skip_del;
  wire tc_now = tc_seen | transfer_end_input;
  wire end_trk = (sec >= last_sector_number) & ~(opc_mt & ~head_select);
  wire fin_ok = (sector_done & (tc_now | del_seen)) | (skip_del & tc_now);
  wire fin_eot = next_done & ~fin_ok & end_trk;
  wire fail = abort | nodata | addr_crc | data_bad | fin_eot;
  wire give = st_data & rd_sector & disk_byte_valid & (bcnt < xfer_len);
  wire pop = (rd_data & st_data & ~mode[`MODE_DMA_BIT]) | (dma_req & dma_ack);
  wire next_hold_valid = give | (hold_valid & ~pop);
  wire res_last = rd_data & st_result & (ridx == `RESULT_LAST);
  wire enter_result = st_result ? 1'b0 :
                      (next_state == fdc_rd_pkg::S_RESULT);
  wire enter_search = ~st_search & (next_state == fdc_rd_pkg::S_SEARCH);

  // result bytes
  wire [7:0] st0 = {1'b0, term_abn, 3'h0, head_select, drive_select};
  wire [7:0] res [0:6];
  assign res[0] = st0;
  assign res[1] = st1;
  assign res[2] = st2;
  assign res[3] = trk;
  assign res[4] = hdn;
  assign res[5] = sec;
  assign res[6] = sz;
  wire [7:0] data_byte = st_result ? res[ridx] : dma_data;
  wire [31:0] rd_mux = sel_data ? {24'h0, data_byte} :
                       sel_stat ? {23'h0, state, hold_valid, int_req} :
                       sel_mode ? {24'h0, mode} : 32'h0;

  sector_id_match u_match (
    .want_track(trk),
    .want_head(hdn),
    .want_sector(sec),
    .want_size(sz),
    .got_track(id_track),
    .got_head(id_head),
    .got_sector(id_sector),
    .got_size(id_size),
    .match(id_match),
    .bad_track(id_bad_trk),
    .wrong_track(id_wrong_trk)
  );

  always_comb
  begin
    next_state = state;
    unique case (state)
      fdc_rd_pkg::S_IDLE:
        if (opc_ok)
          next_state = fdc_rd_pkg::S_CMD;
      fdc_rd_pkg::S_CMD:
        if (cmd_last)
          next_state = seek_en ? fdc_rd_pkg::S_SEEK : fdc_rd_pkg::S_SEARCH;
      fdc_rd_pkg::S_SEEK:
        if (abort)
          next_state = fdc_rd_pkg::S_RESULT;
        else if (seek_done)
          next_state = fdc_rd_pkg::S_SETTLE;
      fdc_rd_pkg::S_SETTLE:
        if (abort)
          next_state = fdc_rd_pkg::S_RESULT;
        else if (settle == 12'h000)
          next_state = fdc_rd_pkg::S_SEARCH;
      fdc_rd_pkg::S_SEARCH:
        if (abort | nodata | addr_crc)
          next_state = fdc_rd_pkg::S_RESULT;
        else if (id_hit)
          next_state = fdc_rd_pkg::S_DATA;
      fdc_rd_pkg::S_DATA:
        if (fin_ok | fin_eot | data_bad)
          next_state = fdc_rd_pkg::S_RESULT;
        else if (next_done)
          next_state = fdc_rd_pkg::S_SEARCH;
      fdc_rd_pkg::S_RESULT:
        if (res_last)
          next_state = fdc_rd_pkg::S_IDLE;
      default:
        next_state = fdc_rd_pkg::S_IDLE;
    endcase
  end

  // apb answer: one wait state, data captured in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= acc_first;
      pslverr <= acc_first & ~addr_ok;
      prdata <= (acc_first & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  // command intake
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= fdc_rd_pkg::S_IDLE;
      pcnt <= 3'h0;
      opc_mt <= 1'b0;
      opc_sk <= 1'b0;
      mode <= `MODE_RESET;
      for (int i = 0; i < 8; i++)
        prm[i] <= 8'h00;
    end
    else
    begin
      state <= next_state;
      if (wr_mode)
        mode <= pwdata[7:0];
      if (opc_ok)
      begin
        opc_mt <= pwdata[7];
        opc_sk <= pwdata[5];
        pcnt <= 3'h0;
      end
      else if (wr_data & st_cmd)
      begin
        prm[pcnt] <= pwdata[7:0];
        pcnt <= pcnt + 3'h1;
      end
    end
  end

  // working sector id and its advance
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trk <= 8'h00;
      hdn <= 8'h00;
      sec <= 8'h00;
      head_select <= 1'b0;
      drive_select <= 2'h0;
    end
    else if (cmd_last)
    begin
      trk <= prm[1];
      hdn <= prm[2];
      sec <= prm[3];
      head_select <= prm[0][2];
      drive_select <= prm[0][1:0];
    end
    else if (next_done)
    begin
      if (sec < last_sector_number)
        sec <= sec + 8'h01;
      else if (opc_mt & ~head_select)
      begin
        hdn <= 8'h01;
        head_select <= 1'b1;
        sec <= 8'h01;
      end
      else
      begin
        trk <= trk + 8'h01;
        sec <= 8'h01;
        if (opc_mt)
        begin
          hdn <= 8'h00;
          head_select <= 1'b0;
        end
      end
    end
  end

  // status bytes and termination
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st1 <= 8'h00;
      st2 <= 8'h00;
      term_abn <= 1'b0;
      tc_seen <= 1'b0;
    end
    else if (cmd_last)
    begin
      st1 <= 8'h00;
      st2 <= 8'h00;
      term_abn <= 1'b0;
      tc_seen <= 1'b0;
    end
    else
    begin
      if (st_search & id_valid & id_bad_trk)
        st2[`ST2_BAD_BIT] <= 1'b1;
      if (st_search & id_valid & id_wrong_trk)
        st2[`ST2_WRONG_BIT] <= 1'b1;
      if (nodata)
        st1[`ST1_NODATA_BIT] <= 1'b1;
      if (addr_crc | data_bad)
        st1[`ST1_CRC_BIT] <= 1'b1;
      if (data_bad)
        st2[`ST2_CRC_BIT] <= 1'b1;
      if (fin_eot)
        st1[`ST1_EOT_BIT] <= 1'b1;
      if (st_data & mark_valid & mark_deleted)
        st2[`ST2_CM_BIT] <= 1'b1;
      if (fail)
        term_abn <= 1'b1;
      if ((st_search | st_data) & transfer_end_input)
        tc_seen <= 1'b1;
    end
  end

  // sector reading, revolutions, settle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      revs <= 2'h0;
      rd_sector <= 1'b0;
      del_seen <= 1'b0;
      bcnt <= 14'h0000;
      settle <= 12'h000;
      seek_req <= 1'b0;
      seek_track <= 8'h00;
      read_gate <= 1'b0;
    end
    else
    begin
      if (enter_search)
        revs <= 2'h0;
      else if (st_search & index_pulse)
        revs <= revs + 2'h1;
      if (~st_data)
        rd_sector <= 1'b0;
      else if (mark_valid & ~(mark_deleted & opc_sk))
        rd_sector <= 1'b1;
      if (id_hit)
        del_seen <= 1'b0;
      else if (st_data & mark_valid)
        del_seen <= mark_deleted & ~opc_sk;
      if (id_hit)
        bcnt <= 14'h0000;
      else if (st_data & rd_sector & disk_byte_valid & ~&bcnt)
        bcnt <= bcnt + 14'h0001;
      if (st_seek & seek_done)
        settle <= 12'(mode[7:4] * `SETTLE_UNIT_CYC);
      else if (st_settle & (settle != 12'h000))
        settle <= settle - 12'h001;
      if (cmd_last & seek_en)
        seek_req <= 1'b1;
      else if (seek_done | abort)
        seek_req <= 1'b0;
      if (cmd_last)
        seek_track <= prm[1];
      read_gate <= (next_state == fdc_rd_pkg::S_SEARCH) |
                   (next_state == fdc_rd_pkg::S_DATA);
    end
  end

  // byte hand-off, interrupt, result pointer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_valid <= 1'b0;
      dma_data <= 8'h00;
      dma_req <= 1'b0;
      int_req <= 1'b0;
      ridx <= 3'h0;
    end
    else
    begin
      hold_valid <= next_hold_valid;
      if (give)
        dma_data <= disk_byte;
      dma_req <= next_hold_valid & mode[`MODE_DMA_BIT];
      if (enter_result)
        int_req <= 1'b1;
      else if (rd_data & st_result)
        int_req <= 1'b0;
      if (enter_result)
        ridx <= 3'h0;
      else if (rd_data & st_result)
        ridx <= ridx + 3'h1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence last_param_s;
    cmd_last;
  endsequence
  sequence abort_s;
    abort;
  endsequence

  a_param_start: assert property (last_param_s |=>
    (state == fdc_rd_pkg::S_SEEK) || (state == fdc_rd_pkg::S_SEARCH))
    else $error("search or seek did not follow the last parameter");
  a_sector_step: assert property ((next_done && sec < last_sector_number) |=>
    sec == $past(sec) + 8'h01)
    else $error("sector number did not advance by one");
  a_side_switch: assert property (
    (next_done && sec >= last_sector_number && opc_mt && !head_select) |=>
    (head_select && hdn == 8'h01 && sec == 8'h01))
    else $error("multi-side read did not move to head one");
  a_tc_stop: assert property ((sector_done && tc_now) |=>
    (st_result && !term_abn))
    else $error("terminal count did not end the read normally");
  a_track_end: assert property (fin_eot |=>
    (st1[`ST1_EOT_BIT] && term_abn && st_result))
    else $error("end of track not reported");
  a_size_len: assert property ((st_data && sz == 8'h03) |->
    xfer_len == 14'h0400)
    else $error("size code three is not 1024 bytes");
  a_short_len: assert property ((st_data && sz == 8'h00 && dtl < 8'h80) |->
    (xfer_len == {6'h00, dtl}))
    else $error("short data length not honoured");
  a_seek_gate: assert property ($rose(seek_req) |->
    (mode[`MODE_IPS_BIT] && implied_seek_flag) ##1 st_seek)
    else $error("seek without both implied seek enables");
  a_hdr_crc: assert property (addr_crc |=>
    (st1[`ST1_CRC_BIT] && st_result && term_abn))
    else $error("header crc error not reported");
  a_no_data: assert property (nodata |=> (st1[`ST1_NODATA_BIT] && term_abn))
    else $error("missing sector not reported");
  a_skip_del: assert property ((skip_del && !fin_ok && !fin_eot) |=>
    (st2[`ST2_CM_BIT] && st_search))
    else $error("deleted sector not skipped");
  a_data_crc: assert property (data_bad |=>
    (st1[`ST1_CRC_BIT] && st2[`ST2_CRC_BIT] && term_abn))
    else $error("data crc error not reported in both bytes");
  a_abort_res: assert property (abort_s |=> st_result ##1 int_req)
    else $error("abort did not reach the result phase");
  a_exec_irq: assert property ($rose(st_result) |-> int_req)
    else $error("no interrupt at end of execution");
  a_next_track: assert property (
    (fin_ok && !opc_mt && sec >= last_sector_number) |=>
    (trk == $past(trk) + 8'h01 && sec == 8'h01 && hdn == $past(hdn)))
    else $error("single side end values wrong");

endmodule : fdc_read_data_sequencer

`default_nettype wire

// *** include/fdc_rd_defs.svh ***
// Operation
// - host writes opcode plus eight parameters; last parameter starts the seek or the header search
// - after each sector the sector number advances by one and is sought
// - multi-side reads head zero to the last sector, then head one from one
// - terminal count input ends reading; the host side must raise it in time
// - passing the last sector number, except on head zero of a multi-side read, stops with an end-of-track error
// - size code n selects 128 shifted left by n bytes, codes 0 to 6
// - size code zero: data length bytes sent, full 128 read and checked
// - seek and head settle only when both implied seek enables are set
// - sector found by matching track, head, sector and size against each header
// - header crc error on the matching sector sets status one bit 5, abnormal
// - sector not found sets status one bit 2, abnormal end
// - header track ff sets status two bit 1; any track mismatch, ff included, sets bit 4
// - deleted mark with skip set: sector skipped, status two bit 6, continue
// - deleted mark with skip clear: sector read, status two bit 6, normal end
// - data crc error sets bit 5 of both status bytes, abnormal end
// - sectors follow in logical order until terminal count or an error
// - a data write while waiting on revolutions aborts into the result phase
// - interrupt raised when execution ends, normally or abnormally
// - on error the result bytes name the sector being read; end of track names the next sector
// - single side: sector plus one, or track plus one and sector one
// - multi-side at last sector: head zero goes to head one, head one to next track
`ifndef FDC_RD_DEFS_SVH
`define FDC_RD_DEFS_SVH

`define OFF_DATA 12'h000
`define OFF_STAT 12'h004
`define OFF_MODE 12'h008

`define MODE_RESET 8'h00
`define MODE_IPS_BIT 0
`define MODE_DMA_BIT 1

`define OPC_READ 5'h06
`define PARAM_LAST 3'h7
`define RESULT_LAST 3'h6
`define BAD_TRACK_ID 8'hff
`define SIZE_CODE_MAX 8'h06
`define MIN_SECTOR_BYTES 14'h0080
`define NODATA_INDEX 2'h1

`define ST1_EOT_BIT 7
`define ST1_CRC_BIT 5
`define ST1_NODATA_BIT 2
`define ST2_CM_BIT 6
`define ST2_CRC_BIT 5
`define ST2_WRONG_BIT 4
`define ST2_BAD_BIT 1

`define CLK_PERIOD_NS 5
`define SETTLE_UNIT_NS 1000
`define SETTLE_UNIT_CYC ((`SETTLE_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** include/fdc_rd_pkg.sv ***
package fdc_rd_pkg;

  typedef enum logic [6:0] {
    S_IDLE   = 7'b0000001,
    S_CMD    = 7'b0000010,
    S_SEEK   = 7'b0000100,
    S_SETTLE = 7'b0001000,
    S_SEARCH = 7'b0010000,
    S_DATA   = 7'b0100000,
    S_RESULT = 7'b1000000
  } seq_state_t;

endpackage : fdc_rd_pkg

// *** rtl/sector_id_match.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fdc_rd_defs.svh"

module sector_id_match (
  // commanded id
  input wire logic [7:0] want_track,
  input wire logic [7:0] want_head,
  input wire logic [7:0] want_sector,
  input wire logic [7:0] want_size,
  // header read from disk
  input wire logic [7:0] got_track,
  input wire logic [7:0] got_head,
  input wire logic [7:0] got_sector,
  input wire logic [7:0] got_size,
  // compare results
  output logic match,
  output logic bad_track,
  output logic wrong_track
);

  assign match = (want_track == got_track) && (want_head == got_head) &&
                 (want_sector == got_sector) && (want_size == got_size);
  assign bad_track = (got_track == `BAD_TRACK_ID);
  assign wrong_track = (got_track != want_track);

endmodule : sector_id_match

`default_nettype wire

// *** tb/disk_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module disk_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // drive control
  input wire logic seek_req,
  output logic seek_done,
  // data separator
  output logic index_pulse,
  output logic id_valid,
  output logic [7:0] id_track,
  output logic [7:0] id_head,
  output logic [7:0] id_sector,
  output logic [7:0] id_size,
  output logic id_crc_err,
  output logic mark_valid,
  output logic mark_deleted,
  output logic disk_byte_valid,
  output logic [7:0] disk_byte,
  output logic crc_valid,
  output logic crc_err
);
  int seek_cnt;

  initial
  begin
    {index_pulse, id_valid, mark_valid, disk_byte_valid, crc_valid} = '0;
    {id_track, id_head, id_sector, id_size, id_crc_err} = '0;
    {mark_deleted, disk_byte, crc_err} = '0;
  end

  // head arrives on track a fixed time after the seek starts
  always @(posedge pclk)
  begin
    seek_cnt <= (seek_req && presetn) ? seek_cnt + 1 : 0;
    seek_done <= (seek_cnt == 20);
  end

  task automatic index;
    @(posedge pclk);
    index_pulse <= 1'b1;
    @(posedge pclk);
    index_pulse <= 1'b0;
  endtask : index

  // f: bit2 header crc bad, bit1 deleted mark, bit0 data crc bad
  task automatic sector(input logic [7:0] t, h, s, n, input logic [3:0] f);
    int nb;
    nb = 128 << n;
    @(posedge pclk);
    id_valid <= 1'b1;
    {id_track, id_head, id_sector, id_size, id_crc_err} <= {t, h, s, n, f[2]};
    @(posedge pclk);
    id_valid <= 1'b0;
    // released header lines must not keep showing the last id
    {id_track, id_head, id_sector, id_size, id_crc_err} <= ~{t, h, s, n, f[2]};
    @(posedge pclk);
    mark_valid <= 1'b1;
    mark_deleted <= f[1];
    @(posedge pclk);
    mark_valid <= 1'b0;
    mark_deleted <= ~f[1];
    for (int i = 0; i < nb; i++)
    begin
      disk_byte_valid <= 1'b1;
      disk_byte <= i[7:0] ^ s;
      @(posedge pclk);
      disk_byte_valid <= 1'b0;
      disk_byte <= ~(i[7:0] ^ s);
      repeat (2) @(posedge pclk);
    end
    crc_valid <= 1'b1;
    crc_err <= f[0];
    @(posedge pclk);
    crc_valid <= 1'b0;
    crc_err <= ~f[0];
  endtask : sector
endmodule : disk_model

`default_nettype wire

// *** tb/fdc_read_data_sequencer_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module fdc_read_data_sequencer_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, e;
  logic transfer_end_input, dma_ack, dma_req, int_req;
  logic seek_done, seek_req, head_select, read_gate;
  logic [7:0] dma_data, seek_track, esec;
  logic [1:0] drive_select;
  logic index_pulse, id_valid, id_crc_err, mark_valid, mark_deleted;
  logic disk_byte_valid, crc_valid, crc_err;
  logic [7:0] id_track, id_head, id_sector, id_size, disk_byte;
  int n_errors, n_checks, nbytes, bidx, cyc;

  fdc_read_data_sequencer DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .transfer_end_input(transfer_end_input), .dma_ack(dma_ack),
    .dma_req(dma_req), .dma_data(dma_data), .int_req(int_req),
    .seek_done(seek_done), .seek_req(seek_req), .seek_track(seek_track),
    .drive_select(drive_select), .head_select(head_select),
    .read_gate(read_gate), .index_pulse(index_pulse), .id_valid(id_valid),
    .id_track(id_track), .id_head(id_head), .id_sector(id_sector),
    .id_size(id_size), .id_crc_err(id_crc_err), .mark_valid(mark_valid),
    .mark_deleted(mark_deleted), .disk_byte_valid(disk_byte_valid),
    .disk_byte(disk_byte), .crc_valid(crc_valid), .crc_err(crc_err)
  );

  disk_model disk (
    .pclk(pclk), .presetn(presetn), .seek_req(seek_req),
    .seek_done(seek_done), .index_pulse(index_pulse), .id_valid(id_valid),
    .id_track(id_track), .id_head(id_head), .id_sector(id_sector),
    .id_size(id_size), .id_crc_err(id_crc_err), .mark_valid(mark_valid),
    .mark_deleted(mark_deleted), .disk_byte_valid(disk_byte_valid),
    .disk_byte(disk_byte), .crc_valid(crc_valid), .crc_err(crc_err)
  );

  task automatic final_report;
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] ex, got);
    n_checks++;
    if (got !== ex)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = {31'h0, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cmd(input logic [7:0] op, b1, t, h, s, n, x, l);
    logic [7:0] p [9];
    p = '{op, b1, t, h, s, n, x, 8'h1b, l};
    nbytes = 0;
    foreach (p[i])
      apb(1'b1, 12'h000, {24'h0, p[i]});
  endtask : cmd

  // f bit3 raises terminal count while the sector is in flight
  task automatic sect(input logic [7:0] t, h, s, n, input logic [3:0] f);
    bidx = 0;
    esec = s;
    fork
      disk.sector(t, h, s, n, f);
      begin
        repeat (4) @(posedge pclk);
        transfer_end_input <= f[3];
      end
    join
  endtask : sect

  task automatic result(input logic [7:0] s0, s1, s2, t, h, s, n);
    logic [7:0] ex [7];
    ex = '{s0, s1, s2, t, h, s, n};
    transfer_end_input <= 1'b0;
    repeat (400)
      if (int_req !== 1'b1)
        @(posedge pclk);
    chk("int_req", 32'h1, {31'h0, int_req});
    foreach (ex[i])
    begin
      apb(1'b0, 12'h000, 32'h0);
      chk("result", {24'h0, ex[i]}, q);
    end
  endtask : result

  task automatic one(input logic [7:0] op, l, input logic [3:0] f,
    input int nb, input logic [7:0] s0, s1, s2, rs);
    cmd(op, 8'h00, 8'h05, 8'h00, 8'h01, 8'h00, 8'h09, l);
    sect(8'h05, 8'h00, 8'h01, 8'h00, f);
    chk("bytes", nb, nbytes);
    result(s0, s1, s2, 8'h05, 8'h00, rs, 8'h00);
  endtask : one

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // dma side acknowledges each waiting byte; also the run's watchdog
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      n_errors++;
      final_report();
    end
    dma_ack <= dma_req && !dma_ack;
    if (dma_req && dma_ack)
    begin
      chk("dma_data", {24'h0, bidx[7:0] ^ esec}, {24'h0, dma_data});
      bidx++;
      nbytes++;
    end
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    transfer_end_input = 1'b0;
    dma_ack = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h008, 32'h0);
    chk("mode", 32'h0, q);
    chk("mapped_err", 32'h0, e);
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h4, q);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped_data", 32'h0, q);
    chk("unmapped_err", 32'h1, e);
    apb(1'b1, 12'h008, 32'h03);
    cmd(8'h06, 8'h00, 8'h05, 8'h00, 8'h01, 8'h00, 8'h09, 8'hff);
    repeat (2) @(posedge pclk);
    chk("seek_req", 32'h0, {31'h0, seek_req});
    chk("read_gate", 32'h1, {31'h0, read_gate});
    sect(8'h05, 8'h00, 8'h01, 8'h00, 4'h0);
    sect(8'hff, 8'h00, 8'h02, 8'h00, 4'h0);
    sect(8'h05, 8'h00, 8'h03, 8'h00, 4'h0);
    sect(8'h05, 8'h00, 8'h02, 8'h00, 4'h8);
    chk("bytes", 32'h100, nbytes);
    result(8'h00, 8'h00, 8'h12, 8'h05, 8'h00, 8'h03, 8'h00);
    one(8'h06, 8'h10, 4'h8, 16, 8'h00, 8'h00, 8'h00, 8'h02);
    one(8'h06, 8'hff, 4'h4, 0, 8'h40, 8'h20, 8'h00, 8'h01);
    one(8'h06, 8'hff, 4'h1, 128, 8'h40, 8'h20, 8'h20, 8'h01);
    one(8'h06, 8'hff, 4'h2, 128, 8'h00, 8'h00, 8'h40, 8'h02);
    cmd(8'h26, 8'h00, 8'h05, 8'h00, 8'h01, 8'h00, 8'h09, 8'hff);
    sect(8'h05, 8'h00, 8'h01, 8'h00, 4'h2);
    sect(8'h05, 8'h00, 8'h02, 8'h00, 4'h8);
    chk("bytes", 32'h80, nbytes);
    result(8'h00, 8'h00, 8'h40, 8'h05, 8'h00, 8'h03, 8'h00);
    cmd(8'h06, 8'h00, 8'h05, 8'h00, 8'h01, 8'h00, 8'h09, 8'hff);
    disk.index();
    disk.index();
    result(8'h40, 8'h04, 8'h00, 8'h05, 8'h00, 8'h01, 8'h00);
    for (int n = 1; n < 7; n++)
    begin
      cmd(8'h06, 8'h00, 8'h05, 8'h00, 8'h01, n[7:0], 8'h09, 8'hff);
      sect(8'h05, 8'h00, 8'h01, n[7:0], 4'h8);
      chk("bytes", 32'h80 << n, nbytes);
      result(8'h00, 8'h00, 8'h00, 8'h05, 8'h00, 8'h02, n[7:0]);
    end
    for (int i = 0; i < 4; i++)
    begin
      cmd({i[1], 7'h06}, {5'h00, i[0], 2'h1}, 8'h07, {7'h0, i[0]}, 8'h04,
        8'h00, 8'h04, 8'hff);
      sect(8'h07, {7'h0, i[0]}, 8'h04, 8'h00, 4'h8);
      result({5'h00, i[1] ^ i[0], 2'h1}, 8'h00, 8'h00,
        (i == 2) ? 8'h07 : 8'h08,
        {7'h0, i[1] ^ i[0]}, 8'h01, 8'h00);
      chk("head_select", {31'h0, i[1] ^ i[0]}, {31'h0, head_select});
      chk("drive_select", 32'h1, {30'h0, drive_select});
    end
    cmd(8'h06, 8'h00, 8'h07, 8'h00, 8'h04, 8'h00, 8'h04, 8'hff);
    sect(8'h07, 8'h00, 8'h04, 8'h00, 4'h0);
    result(8'h40, 8'h80, 8'h00, 8'h08, 8'h00, 8'h01, 8'h00);
    apb(1'b1, 12'h008, 32'h13);
    cmd(8'h06, 8'h80, 8'h09, 8'h00, 8'h01, 8'h00, 8'h09, 8'hff);
    repeat (2) @(posedge pclk);
    chk("seek_req", 32'h1, {31'h0, seek_req});
    chk("seek_track", 32'h9, {24'h0, seek_track});
    repeat (100) @(posedge pclk);
    apb(1'b1, 12'h000, 32'h5a);
    result(8'h40, 8'h00, 8'h00, 8'h09, 8'h00, 8'h01, 8'h00);
    final_report();
  end
endmodule : fdc_read_data_sequencer_tb_top

`default_nettype wire
